// ---- grac_pkg.sv ----
// Package for the grouped region access checker: register map, field layout, reset values and codes.
// Assumes a 32-bit AHB-Lite register bus and a 32-bit peripheral reference address.
package grac_pkg;
   // Byte addresses of the registers on the AHB-Lite slave.
   localparam logic [7:0] GRAC_OFF_REGIONS = 8'h00;
   localparam logic [7:0] GRAC_OFF_PRIV = 8'h04;
   localparam logic [7:0] GRAC_OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] GRAC_OFF_IRQ_ENABLE = 8'h0C;
   localparam logic [7:0] GRAC_OFF_IRQ_CLEAR = 8'h10;
   localparam logic [7:0] GRAC_OFF_TRUST = 8'h14;
   // Field positions inside a region register, and the region number bits of a reference offset.
   localparam int GRAC_LOCK_BIT = 7;
   localparam int GRAC_CODE_MSB = 3;
   localparam int GRAC_REGION_MSB = 29;
   localparam int GRAC_REGION_LSB = 26;
   // Lane of region 1 inside the region word.
   localparam int GRAC_R1_LSB = 8;
   // Reset values of the region, privilege and trust registers, and the write mask of a region register.
   localparam logic [7:0] GRAC_REGION_RESET = 8'h00;
   localparam logic [3:0] GRAC_PRIV_RESET = 4'h1;
   localparam logic [3:0] GRAC_TRUST_RESET = 4'h1;
   localparam logic [7:0] GRAC_REG_WMASK = 8'h8F;
   // Interrupt status bit positions.
   localparam int GRAC_EV_DENY = 0;
   localparam int GRAC_EV_LOCKWR = 1;
   localparam int GRAC_EV_UNTRUST = 2;
   localparam int GRAC_NUM_EV = 3;
   // Access kinds of a checked reference.
   typedef enum logic [1:0] {GRAC_READ, GRAC_WRITE, GRAC_FETCH} grac_kind_t;
   // Rights of one privilege level: read, write, execute.
   typedef struct packed {logic r; logic w; logic x;} grac_rights_t;
endpackage : grac_pkg

// ---- grac_decode.sv ----
// Permission code decoder: maps a 4-bit code and privilege level to granted rights.
// Assumes the caller supplies the effective supervisor flag.
`timescale 1ns/1ps
module grac_decode
   import grac_pkg::*;
(
   input wire logic [3:0] code_in, // Permission code of the region.
   input wire logic super_in, // High for supervisor references.
   output grac_rights_t rights_out // Rights granted.
);
   // Supervisor rights per code, packed {r,w,x}.
   grac_rights_t sup_r;
   // User rights per code.
   grac_rights_t usr_r;
   // Table of both levels for the sixteen codes.
   always_comb
   begin
      unique case (code_in)
         4'h0: begin sup_r = 3'b110; usr_r = 3'b000; end
         4'h1: begin sup_r = 3'b100; usr_r = 3'b000; end
         4'h2: begin sup_r = 3'b100; usr_r = 3'b100; end
         4'h3: begin sup_r = 3'b100; usr_r = 3'b000; end
         4'h4: begin sup_r = 3'b110; usr_r = 3'b110; end
         4'h5: begin sup_r = 3'b110; usr_r = 3'b100; end
         4'h6: begin sup_r = 3'b110; usr_r = 3'b110; end
         4'h7: begin sup_r = 3'b000; usr_r = 3'b000; end
         4'h8: begin sup_r = 3'b111; usr_r = 3'b000; end
         4'h9: begin sup_r = 3'b101; usr_r = 3'b000; end
         4'hA: begin sup_r = 3'b101; usr_r = 3'b101; end
         4'hB: begin sup_r = 3'b001; usr_r = 3'b000; end
         4'hC: begin sup_r = 3'b111; usr_r = 3'b111; end
         4'hD: begin sup_r = 3'b111; usr_r = 3'b101; end
         4'hE: begin sup_r = 3'b110; usr_r = 3'b100; end
         4'hF: begin sup_r = 3'b111; usr_r = 3'b001; end
      endcase
   end
   // Pick the level in force.
   assign rights_out = super_in ? sup_r : usr_r;
endmodule : grac_decode

// ---- grac_top.sv ----
// Grouped region access checker with an AHB-Lite register slave and a one-cycle reference checker.
// Assumes a single clock, a synchronous active-low reset and a same-domain reference port.
// Register bus timing: a write completes in its data phase with no wait state.
// A read inserts one wait cycle in which the word is registered.
// The word then stands on hrdata_out through the completing cycle, as the bus expects.
// A refused write answers ERROR over two cycles, the first with ready low.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module grac_top
   import grac_pkg::*;
(
   input wire logic sys_clk_in, // System clock, 50 MHz.
   input wire logic nrst_in, // Synchronous active-low reset.
   input wire logic clk_en_in, // Clock enable; all state freezes while low.
   input wire logic hsel_in, // AHB-Lite slave select.
   input wire logic [31:0] haddr_in, // AHB-Lite address.
   input wire logic [1:0] htrans_in, // AHB-Lite transfer type.
   input wire logic hwrite_in, // AHB-Lite write flag.
   input wire logic [2:0] hsize_in, // AHB-Lite transfer size.
   input wire logic [31:0] hwdata_in, // AHB-Lite write data.
   input wire logic hready_in, // AHB-Lite bus ready.
   input wire logic [1:0] hmaster_in, // Master number of the register access.
   output logic [31:0] hrdata_out, // AHB-Lite read data.
   output logic hreadyout_out, // AHB-Lite slave ready.
   output logic hresp_out, // AHB-Lite response, high for ERROR.
   input wire logic ref_valid_in, // A peripheral reference is offered.
   input wire logic [31:0] ref_offset_in, // Offset of the reference above the peripheral base.
   input wire logic [1:0] ref_kind_in, // Kind: read, write or fetch.
   input wire logic ref_super_in, // Master's own supervisor attribute.
   input wire logic [1:0] ref_master_in, // Master number of the reference.
   input wire logic ref_module_cov_in, // Target is covered by the per-module registers.
   input wire logic ref_module_ok_in, // Verdict of the per-module registers.
   output logic ref_grant_out, // Reference may proceed, registered.
   output logic ref_error_out, // Reference ends with bus error, registered.
   output logic irq_out // Level interrupt.
);
   // Region 0 register: lock, reserved, code.
   logic [7:0] region0_peripheral_permission;
   // Region 1 register: lock, reserved, code.
   logic [7:0] region1_flash_backdoor_permission;
   // One privilege bit per master.
   logic [3:0] master_privilege_bits;
   // One trusted flag per master; master 0 is always trusted.
   logic [3:0] trusted_masters;
   // Sticky event bits.
   logic [GRAC_NUM_EV-1:0] irq_status;
   // Event enables.
   logic [GRAC_NUM_EV-1:0] irq_enable;
   // Data phase state of the bus slave.
   logic dp_active;
   logic dp_write;
   logic [7:0] dp_addr;
   logic dp_trusted;
   // Two-cycle error response state.
   logic err_first;
   logic err_second;
   // High in the single wait cycle of a read data phase, while the word is registered.
   logic rd_wait;

   // Address phase taken when selected, ready and NONSEQ or SEQ.
   wire ap_take = hsel_in && hready_in && htrans_in[1];
   // Master of the address phase is trusted.
   wire ap_trusted = trusted_masters[hmaster_in];
   // Decoded data phase writes.
   wire wr_cycle = dp_active && dp_write && !err_second;
   wire wr_regions = wr_cycle && (dp_addr == GRAC_OFF_REGIONS);
   wire wr_priv = wr_cycle && (dp_addr == GRAC_OFF_PRIV);
   wire wr_enable = wr_cycle && (dp_addr == GRAC_OFF_IRQ_ENABLE);
   wire wr_clear = wr_cycle && (dp_addr == GRAC_OFF_IRQ_CLEAR);
   wire wr_trust = wr_cycle && (dp_addr == GRAC_OFF_TRUST);
   // Any write to a control register by an untrusted master is refused.
   wire ctl_addr = (dp_addr == GRAC_OFF_REGIONS) || (dp_addr == GRAC_OFF_PRIV) || (dp_addr == GRAC_OFF_TRUST);
   wire untrusted_wr = wr_cycle && ctl_addr && !dp_trusted;
   // Lock bits of both regions.
   wire lock0 = region0_peripheral_permission[GRAC_LOCK_BIT];
   wire lock1 = region1_flash_backdoor_permission[GRAC_LOCK_BIT];
   // A trusted write to the region word is refused while the lock bit of either region is set.
   wire lock_wr = wr_regions && dp_trusted && (lock0 || lock1);
   // Final refusal of the data phase.
   wire refuse = untrusted_wr || lock_wr;
   // Accepted writes.
   wire ok_regions = wr_regions && !refuse;
   wire ok_priv = wr_priv && !refuse;
   wire ok_trust = wr_trust && !refuse;
   // Write data lanes of both region registers, reserved bits dropped.
   wire [7:0] wdata_r0 = hwdata_in[7:0] & GRAC_REG_WMASK;
   wire [7:0] wdata_r1 = hwdata_in[GRAC_R1_LSB+7:GRAC_R1_LSB] & GRAC_REG_WMASK;

   // Read mux of the data phase.
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (dp_addr == GRAC_OFF_REGIONS)
      begin
         next_rdata = {16'h0000, region1_flash_backdoor_permission, region0_peripheral_permission};
      end
      else if (dp_addr == GRAC_OFF_PRIV)
      begin
         next_rdata = {28'h0000000, master_privilege_bits};
      end
      else if (dp_addr == GRAC_OFF_IRQ_STATUS)
      begin
         next_rdata = {29'h0, irq_status};
      end
      else if (dp_addr == GRAC_OFF_IRQ_ENABLE)
      begin
         next_rdata = {29'h0, irq_enable};
      end
      else if (dp_addr == GRAC_OFF_TRUST)
      begin
         next_rdata = {28'h0000000, trusted_masters};
      end
   end

   // Reference checking: region selection and rights.
   wire [3:0] ref_region = ref_offset_in[GRAC_REGION_MSB:GRAC_REGION_LSB];
   wire in_r0 = (ref_region == 4'h0);
   wire in_r1 = (ref_region == 4'h1);
   // Other regions are reserved space with no register and grant nothing.
   wire in_impl = in_r0 || in_r1;
   wire [3:0] ref_code = in_r1 ? region1_flash_backdoor_permission[GRAC_CODE_MSB:0]
                               : region0_peripheral_permission[GRAC_CODE_MSB:0];
   // User mode unless both the master's privilege bit and its own supervisor attribute are set.
   wire eff_super = master_privilege_bits[ref_master_in] && ref_super_in;
   grac_rights_t ref_rights;
   grac_decode u_decode
   (
      .code_in(ref_code),
      .super_in(eff_super),
      .rights_out(ref_rights)
   );
   // Right required by the kind of reference.
   wire kind_ok = (ref_kind_in == GRAC_READ) ? ref_rights.r :
                  (ref_kind_in == GRAC_WRITE) ? ref_rights.w :
                  (ref_kind_in == GRAC_FETCH) ? ref_rights.x : 1'b0;
   // Covered modules take the per-module verdict instead of region 0.
   wire by_module = in_r0 && ref_module_cov_in;
   wire ref_ok = by_module ? ref_module_ok_in : (in_impl && kind_ok);
   wire ref_deny = ref_valid_in && !ref_ok;

   // Event pulses, set beats clear.
   wire [GRAC_NUM_EV-1:0] ev = {untrusted_wr, lock_wr, ref_deny};
   wire [GRAC_NUM_EV-1:0] clr = wr_clear ? hwdata_in[GRAC_NUM_EV-1:0] : {GRAC_NUM_EV{1'b0}};

   // Bus slave phase tracking and two-cycle error response.
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         dp_active <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         dp_trusted <= 1'b0;
         err_first <= 1'b0;
         err_second <= 1'b0;
         rd_wait <= 1'b0;
         hrdata_out <= 32'h0000_0000;
      end
      else if (clk_en_in)
      begin
         err_first <= refuse;
         err_second <= err_first;
         if (rd_wait)
         begin
            // Wait cycle of a read: the word is fetched now so that it stands in the completing cycle.
            rd_wait <= 1'b0;
            hrdata_out <= next_rdata;
         end
         else if (!refuse)
         begin
            // Ready cycle: take the next address phase, if any.
            dp_active <= ap_take;
            dp_write <= hwrite_in;
            dp_addr <= haddr_in[7:0];
            dp_trusted <= ap_trusted;
            rd_wait <= ap_take && !hwrite_in;
         end
         else
         begin
            // A refused phase stalls one cycle for the ERROR pair.
            dp_active <= 1'b0;
         end
      end
   end

   // Region registers; only reset clears the lock bit.
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         region0_peripheral_permission <= GRAC_REGION_RESET;
         region1_flash_backdoor_permission <= GRAC_REGION_RESET;
      end
      else if (clk_en_in && ok_regions)
      begin
         region0_peripheral_permission <= wdata_r0;
         region1_flash_backdoor_permission <= wdata_r1;
      end
   end

   // Privilege and trust registers; master 0 stays trusted and privileged.
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         master_privilege_bits <= GRAC_PRIV_RESET;
         trusted_masters <= GRAC_TRUST_RESET;
      end
      else if (clk_en_in)
      begin
         if (ok_priv)
         begin
            master_privilege_bits <= hwdata_in[3:0] | GRAC_PRIV_RESET;
         end
         if (ok_trust)
         begin
            trusted_masters <= hwdata_in[3:0] | GRAC_TRUST_RESET;
         end
      end
   end

   // Interrupt status, enable and verdict outputs.
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         irq_status <= {GRAC_NUM_EV{1'b0}};
         irq_enable <= {GRAC_NUM_EV{1'b0}};
         ref_grant_out <= 1'b0;
         ref_error_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         irq_status <= (irq_status & ~clr) | ev;
         if (wr_enable)
         begin
            irq_enable <= hwdata_in[GRAC_NUM_EV-1:0];
         end
         ref_grant_out <= ref_valid_in && ref_ok;
         ref_error_out <= ref_deny;
      end
   end

   // Bus answer: a read waits one cycle; ERROR takes two cycles, first with ready low.
   assign hresp_out = refuse || err_first;
   assign hreadyout_out = !refuse && !rd_wait;
   assign irq_out = |(irq_status & irq_enable);
endmodule : grac_top

// ---- grac_props.sv ----
// Checker for the region access checker: bus answers and reference verdicts at the top ports.
// Assumes one clock domain and that the bench keeps clk_en_in high.
`timescale 1ns/1ps
module grac_props
   import grac_pkg::*;
(
   input wire logic sys_clk_in, // System clock.
   input wire logic nrst_in, // Synchronous active-low reset.
   input wire logic clk_en_in, // Clock enable.
   input wire logic hsel_in, // Slave select.
   input wire logic [1:0] htrans_in, // Transfer type.
   input wire logic hwrite_in, // Write flag.
   input wire logic hready_in, // Bus ready.
   input wire logic hreadyout_out, // Slave ready.
   input wire logic hresp_out, // Error response.
   input wire logic ref_valid_in, // Reference offered.
   input wire logic [31:0] ref_offset_in, // Reference offset.
   input wire logic [1:0] ref_kind_in, // Reference kind.
   input wire logic ref_module_cov_in, // Target covered per module.
   input wire logic ref_module_ok_in, // Per-module verdict.
   input wire logic ref_grant_out, // Grant pulse.
   input wire logic ref_error_out // Error pulse.
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   // Every offered reference gets exactly one answer in the next cycle.
   a_one_answer: assert property (ref_valid_in && clk_en_in |=> ref_grant_out != ref_error_out)
      else $error("reference not answered by exactly one pulse");
   // No answer appears without a reference.
   a_idle_quiet: assert property (!ref_valid_in && clk_en_in |=> !ref_grant_out && !ref_error_out)
      else $error("answer pulse without a reference");
   // Regions two to fifteen have no register and are always refused.
   a_upper_denied: assert property (ref_valid_in && clk_en_in && ref_offset_in[29:27] != 3'h0
      && !ref_module_cov_in |=> ref_error_out) else $error("upper region reference granted");
   // The unused kind code is never granted outside covered modules.
   a_bad_kind: assert property (ref_valid_in && clk_en_in && ref_kind_in == 2'h3 && !ref_module_cov_in
      |=> ref_error_out) else $error("unused kind granted");
   // Covered modules follow the per-module verdict, not the region-0 code.
   a_module_rule: assert property (ref_valid_in && clk_en_in && ref_module_cov_in && !ref_kind_in[1]
      && ref_offset_in[29:26] == 4'h0 |=> ref_grant_out == $past(ref_module_ok_in))
      else $error("per-module verdict ignored");
   // An error wait cycle is always completed by a ready cycle that still shows error.
   a_error_pair: assert property (!hreadyout_out && hresp_out |=> hreadyout_out && hresp_out)
      else $error("error response not a two-cycle pair");
   // The completing error cycle always follows a wait cycle with error.
   a_error_tail: assert property (hresp_out && hreadyout_out |-> $past(hresp_out) && !$past(hreadyout_out))
      else $error("error completion without first error cycle");
   // Reads are never refused: one wait cycle, then an OKAY completion.
   a_read_okay: assert property (hsel_in && htrans_in[1] && hready_in && !hwrite_in
      |=> !hreadyout_out && !hresp_out ##1 hreadyout_out && !hresp_out)
      else $error("read not answered OKAY after one wait cycle");
   c_grant: cover property (ref_valid_in ##1 ref_grant_out);
   c_refused: cover property ($fell(hreadyout_out));
   c_covered: cover property (ref_valid_in && ref_module_cov_in ##1 ref_grant_out);
endmodule : grac_props
bind grac_top grac_props u_props (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
   .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .ref_valid_in(ref_valid_in),
   .ref_offset_in(ref_offset_in), .ref_kind_in(ref_kind_in), .ref_module_cov_in(ref_module_cov_in),
   .ref_module_ok_in(ref_module_ok_in), .ref_grant_out(ref_grant_out), .ref_error_out(ref_error_out));

// ---- grac_master_model.sv ----
// Model of a bus master issuing one-cycle peripheral references to the checker.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ps
module grac_master_model (
   input wire logic sys_clk_in, // System clock.
   input wire logic grant_in, // Grant pulse from the checker.
   input wire logic error_in, // Error pulse from the checker.
   output logic ref_valid_out = 1'b0, // Reference offered.
   output logic [31:0] ref_offset_out = 32'h0, // Reference offset.
   output logic [1:0] ref_kind_out = 2'h0, // Read, write or fetch.
   output logic ref_super_out = 1'b0, // Own supervisor attribute.
   output logic [1:0] ref_master_out = 2'h0, // Master number.
   output logic ref_cov_out = 1'b0, // Target covered per module.
   output logic ref_ok_out = 1'b0 // Per-module verdict.
);
   // Offers one reference for one cycle, then takes the pulse that answers it.
   task automatic issue(input logic [31:0] off, input logic [1:0] k, input logic s, input logic [1:0] m,
      input logic cov, input logic ok, output logic g, output logic e);
      ref_valid_out <= 1'b1;
      ref_offset_out <= off;
      ref_kind_out <= k;
      ref_super_out <= s;
      ref_master_out <= m;
      ref_cov_out <= cov;
      ref_ok_out <= ok;
      @(posedge sys_clk_in);
      // Released offset is scrambled so a stale value cannot pass for a new one.
      ref_valid_out <= 1'b0;
      ref_offset_out <= ~off;
      @(negedge sys_clk_in);
      g = grant_in;
      e = error_in;
      @(posedge sys_clk_in);
   endtask : issue
endmodule : grac_master_model

// ---- testbench.sv ----
// Self-checking bench for the region access checker: register bus tasks and reference sequences.
// Assumes reads with wait cycles whose data stand in the completing cycle of the data phase.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("FAIL at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench
   import grac_pkg::*;
;
   logic clk = 1'b0, nrst = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0, hmaster = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, ref_off;
   logic exp_g;
   wire logic [31:0] hrdata, off;
   wire logic hrdy, hresp, irq, grant, err, valid, sup, cov, ok;
   wire logic [1:0] kind, mst;
   int num_errors = 0, checked = 0, c, i;
   // Allowed rights per code: supervisor r w x, then user r w x.
   logic [5:0] tbl [16] = '{6'h30, 6'h20, 6'h24, 6'h20, 6'h36, 6'h34, 6'h36, 6'h00,
      6'h38, 6'h28, 6'h2D, 6'h08, 6'h3F, 6'h3D, 6'h34, 6'h39};
   grac_master_model pm (.sys_clk_in(clk), .grant_in(grant), .error_in(err), .ref_valid_out(valid),
      .ref_offset_out(off), .ref_kind_out(kind), .ref_super_out(sup), .ref_master_out(mst),
      .ref_cov_out(cov), .ref_ok_out(ok));
   grac_top uut (.sys_clk_in(clk), .nrst_in(nrst), .clk_en_in(1'b1), .hsel_in(1'b1), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
      .hmaster_in(hmaster), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .ref_valid_in(valid), .ref_offset_in(off), .ref_kind_in(kind), .ref_super_in(sup),
      .ref_master_in(mst), .ref_module_cov_in(cov), .ref_module_ok_in(ok), .ref_grant_out(grant),
      .ref_error_out(err), .irq_out(irq));
   initial forever #10 clk = ~clk;
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   // Waits, with a bound, for hready sampled high at a falling edge; the response is taken there.
   task automatic wait_rdy(output logic er);
      logic r;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         r = hrdy;
         er = hresp;
         // Read data stand in the completing cycle; the last sample is the one kept.
         rd = hrdata;
         @(posedge clk);
         n++;
      end
      while (!r && n < 20);
      if (!r)
      begin
         num_errors++;
         print_verdict();
      end
   endtask : wait_rdy
   // One single word transfer; read data are taken with the completing ready, then one idle cycle.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] m,
      input logic exp_er);
      logic er;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hmaster <= m;
      wait_rdy(er);
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(er);
      `CHK(er, exp_er)
      @(negedge clk);
      @(posedge clk);
   endtask : bus
   // Reads a register and compares the word.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 2'h0, 1'b0);
      `CHK(rd, exp)
   endtask : rd_chk
   // Issues one reference and compares grant and error against the expected verdict.
   task automatic ref_chk(input logic [31:0] o, input logic [1:0] k, input logic s, input logic [1:0] m,
      input logic cv, input logic okv, input logic exp_g);
      logic g, e;
      pm.issue(o, k, s, m, cv, okv, g, e);
      `CHK(g, exp_g)
      `CHK(e, !exp_g)
   endtask : ref_chk
   // Main sequence: reset values, every code, upper regions, interrupts, trust, lock and a second reset.
   initial
   begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h1);
      rd_chk(8'h40, 32'h0);
      bus(1'b1, 8'h0C, 32'h7, 2'h0, 1'b0);
      for (c = 0; c < 16; c++)
      begin
         bus(1'b1, 8'h00, {16'h0, 4'h0, c[3:0], 4'h0, c[3:0]}, 2'h0, 1'b0);
         rd_chk(8'h00, {16'h0, 4'h0, c[3:0], 4'h0, c[3:0]});
         for (i = 0; i < 12; i++)
         begin
            // Odd steps hit the first word of region 1, even ones the last word of region 0.
            ref_off = i[0] ? 32'h0400_0000 : 32'h03FF_FFFC;
            exp_g = tbl[c][(i / 6 == 1 ? 5 : 2) - (i / 2) % 3];
            ref_chk(ref_off, 2'((i / 2) % 3), 1'(i / 6), 2'h0, 1'b0, 1'b0, exp_g);
         end
      end
      for (c = 2; c < 16; c++)
         ref_chk({2'h0, c[3:0], 26'h0}, 2'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
      ref_chk(32'h0000_1000, 2'h3, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
      `CHK(irq, 1'b1)
      rd_chk(8'h08, 32'h1);
      bus(1'b1, 8'h10, 32'h7, 2'h0, 1'b0);
      `CHK(irq, 1'b0)
      bus(1'b1, 8'h00, 32'h0000_0707, 2'h0, 1'b0);
      ref_chk(32'h0000_1000, 2'h0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1);
      ref_chk(32'h0000_1000, 2'h1, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0);
      bus(1'b1, 8'h00, 32'h0, 2'h0, 1'b0);
      bus(1'b1, 8'h04, 32'h0, 2'h0, 1'b0);
      rd_chk(8'h04, 32'h1);
      ref_chk(32'h0000_1000, 2'h0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0);
      bus(1'b1, 8'h04, 32'h2, 2'h0, 1'b0);
      ref_chk(32'h0000_1000, 2'h1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
      bus(1'b1, 8'h0C, 32'h1, 2'h0, 1'b0);
      bus(1'b1, 8'h00, 32'h0000_0505, 2'h2, 1'b1);
      bus(1'b1, 8'h04, 32'h0, 2'h1, 1'b1);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h3);
      bus(1'b1, 8'h10, 32'h1, 2'h0, 1'b0);
      `CHK(irq, 1'b0)
      rd_chk(8'h08, 32'h4);
      bus(1'b1, 8'h14, 32'h4, 2'h0, 1'b0);
      rd_chk(8'h14, 32'h5);
      bus(1'b1, 8'h00, 32'h0000_0505, 2'h2, 1'b0);
      rd_chk(8'h00, 32'h0505);
      bus(1'b1, 8'h00, 32'h0000_0084, 2'h0, 1'b0);
      bus(1'b1, 8'h00, 32'h0, 2'h0, 1'b1);
      rd_chk(8'h00, 32'h84);
      rd_chk(8'h08, 32'h6);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_chk(8'h00, 32'h0);
      ref_chk(32'h0000_1000, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
      ref_chk(32'h0000_1000, 2'h1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1);
      print_verdict();
   end
endmodule : testbench
